// ---- src/dpot_host.sv ----
// host-side command timing guard for a DDR3 device
// Behaviour
// - fixed chop-4 write: latency+2+rounded recovery before clock-enable low
// - fixed chop-4 write-ap: latency+2+recovery+1 before power-down
// - power-down no sooner than one cycle after refresh
// - after mode set, wait mode update delay before power-down
// - termination control high at least 4 cycles for chop-4 or no write
// - termination control high at least 6 cycles for burst-eight write
// - first strobe rising edge at least 40 cycles after leveling programmed
// - strobe drive enabled at least 25 cycles after leveling programmed
// - at least 110 ns from refresh to next activate or refresh
// - refresh on average within 7.8 us, 3.9 us when hot
// - reads and termination commands use the longer DLL exit delay
// - write recovery ns over clock period rounds up to whole cycles
// - refresh interval counted in cycles, so a stretched clock lengthens it in time
`timescale 1ns/1ps
`default_nettype none
module dpot_host (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic       REQ_VALID_IN,
  input  wire logic [3:0] REQ_CMD_IN,
  input  wire logic       REQ_CHOP_IN,
  input  wire logic [4:0] CFG_COL_WR_LAT_IN,
  input  wire logic [4:0] CFG_ADD_LAT_IN,
  input  wire logic [4:0] CFG_RECOV_IN,
  input  wire logic       CFG_CHOP4_FIXED_IN,
  input  wire logic       CFG_HOT_IN,
  output var  logic       REQ_DONE_OUT,
  output var  logic       REQ_REJECT_OUT,
  output var  logic       CMD_VALID_OUT,
  output var  logic [3:0] CMD_CODE_OUT,
  output var  logic       CKE_OUT,
  output var  logic       TERM_OUT,
  output var  logic       DQS_OE_OUT,
  output var  logic       DQS_OUT,
  output var  logic       REFRESH_DUE_OUT
);

  dpot_pkg::dpot_state_t state;
  dpot_pkg::dpot_state_t next_state;
  dpot_pkg::dpot_cmd_t   cmd;
  logic [6:0] pd_wait;
  logic [6:0] next_pd_wait;
  logic [2:0] rfc_wait;
  logic [2:0] next_rfc_wait;
  logic [3:0] exit_wait;
  logic [3:0] next_exit_wait;
  logic [8:0] ref_cnt;
  logic [8:0] next_ref_cnt;
  logic [2:0] term_cnt;
  logic [2:0] next_term_cnt;
  logic [5:0] lvl_cnt;
  logic [5:0] next_lvl_cnt;
  logic       chop_q;
  logic       next_chop_q;
  logic       next_done;
  logic       next_reject;
  logic       next_cmd_valid;
  logic [3:0] next_cmd_code;
  logic       next_cke;
  logic       next_term;
  logic       next_dqs_oe;
  logic       next_dqs;
  logic       next_ref_due;
  logic [6:0] write_latency;
  logic [6:0] write_pd_delay;
  logic [6:0] write_ap_pd_delay;
  logic [6:0] pd_load;
  logic [6:0] pd_dec;
  logic [8:0] ref_due_point;
  logic       is_dll;
  logic       chop;
  logic       allowed;
  logic       take;
  logic       go;

  assign cmd = dpot_pkg::dpot_cmd_t'(REQ_CMD_IN);
  // limits follow the live configuration inputs
  assign write_latency = 7'(CFG_COL_WR_LAT_IN) + 7'(CFG_ADD_LAT_IN);
  assign write_pd_delay = write_latency + 7'(dpot_pkg::WRITE_RECOVERY_CYCLES)
    + (CFG_CHOP4_FIXED_IN ? 7'(dpot_pkg::CHOP4_FIXED_EXTRA)
                          : 7'(dpot_pkg::BURST_EIGHT_EXTRA));
  assign write_ap_pd_delay = write_latency + 7'(CFG_RECOV_IN)
    + 7'(dpot_pkg::WRITE_AP_EXTRA)
    + (CFG_CHOP4_FIXED_IN ? 7'(dpot_pkg::CHOP4_FIXED_EXTRA)
                          : 7'(dpot_pkg::BURST_EIGHT_EXTRA));
  // counted in cycles, so a slower clock only makes refresh later
  assign ref_due_point = CFG_HOT_IN ?
    9'(dpot_pkg::REFRESH_INTERVAL_HOT_CYCLES - dpot_pkg::REFRESH_MARGIN_CYCLES)
    : 9'(dpot_pkg::REFRESH_INTERVAL_CYCLES - dpot_pkg::REFRESH_MARGIN_CYCLES);

  always_comb
  begin
    // writes drive termination, so they wait like reads
    is_dll = (cmd == dpot_pkg::CMD_READ) || (cmd == dpot_pkg::CMD_READ_AP)
      || (cmd == dpot_pkg::CMD_WRITE) || (cmd == dpot_pkg::CMD_WRITE_AP);
    chop = CFG_CHOP4_FIXED_IN || REQ_CHOP_IN;
    take = REQ_VALID_IN && (cmd != dpot_pkg::CMD_NOP);
    unique case (state)
      dpot_pkg::ST_ACTIVE:
      begin
        allowed = (cmd != dpot_pkg::CMD_PD_EXIT)
          && !(REFRESH_DUE_OUT && cmd != dpot_pkg::CMD_REFRESH)
          && !((cmd == dpot_pkg::CMD_ACTIVATE || cmd == dpot_pkg::CMD_REFRESH)
               && rfc_wait != 3'h0)
          && !(cmd == dpot_pkg::CMD_PD_ENTER && pd_wait != 7'h00)
          && !(exit_wait > (is_dll ? 4'h0 : 4'(dpot_pkg::EXIT_DLL_CYCLES
               - dpot_pkg::EXIT_FAST_CYCLES)));
      end
      dpot_pkg::ST_PWRDN:
      begin
        allowed = (cmd == dpot_pkg::CMD_PD_EXIT);
      end
      dpot_pkg::ST_LEVEL:
      begin
        allowed = 1'b0;
      end
      default:
      begin
        allowed = 1'b0;
      end
    endcase
    go = take && allowed;
    next_done = go;
    next_reject = take && !allowed;
    next_cmd_valid = go && (cmd != dpot_pkg::CMD_PD_ENTER)
      && (cmd != dpot_pkg::CMD_PD_EXIT);
    next_cmd_code = next_cmd_valid ? REQ_CMD_IN : 4'h0;
    next_chop_q = go ? chop : chop_q;
    // power-down guard keeps the longest pending delay
    pd_dec = (pd_wait != 7'h00) ? pd_wait - 7'h01 : 7'h00;
    pd_load = 7'h00;
    if (go)
    begin
      unique case (cmd)
        dpot_pkg::CMD_WRITE:    pd_load = write_pd_delay - 7'h01;
        dpot_pkg::CMD_WRITE_AP: pd_load = write_ap_pd_delay - 7'h01;
        dpot_pkg::CMD_REFRESH:
          pd_load = 7'(dpot_pkg::REFRESH_TO_POWERDOWN_DELAY - 1);
        dpot_pkg::CMD_MODESET,
        dpot_pkg::CMD_LEVEL:
          pd_load = 7'(dpot_pkg::MODE_UPDATE_DELAY - 1);
        default:                pd_load = 7'h00;
      endcase
    end
    next_pd_wait = (pd_load > pd_dec) ? pd_load : pd_dec;
    if (go && cmd == dpot_pkg::CMD_REFRESH)
      next_rfc_wait = 3'(dpot_pkg::REFRESH_CYCLE_CYCLES - 1);
    else
      next_rfc_wait = (rfc_wait != 3'h0) ? rfc_wait - 3'h1 : 3'h0;
    if (go && cmd == dpot_pkg::CMD_PD_EXIT)
      next_exit_wait = 4'(dpot_pkg::EXIT_DLL_CYCLES - 1);
    else
      next_exit_wait = (exit_wait != 4'h0) ? exit_wait - 4'h1 : 4'h0;
    // refresh age saturates; when active, due blocks all but refresh
    if (go && cmd == dpot_pkg::CMD_REFRESH)
      next_ref_cnt = 9'h000;
    else
      next_ref_cnt = (ref_cnt != 9'h1ff) ? ref_cnt + 9'h001 : ref_cnt;
    next_ref_due = !(go && cmd == dpot_pkg::CMD_REFRESH)
      && (ref_cnt >= ref_due_point);
    // termination held for the burst's high time
    if (go && (cmd == dpot_pkg::CMD_WRITE || cmd == dpot_pkg::CMD_WRITE_AP))
    begin
      next_term = 1'b1;
      next_term_cnt = chop ? 3'(dpot_pkg::TERM_HIGH_TIME_SHORT - 1)
                           : 3'(dpot_pkg::TERM_HIGH_TIME_LONG - 1);
    end
    else
    begin
      next_term = (term_cnt != 3'h0);
      next_term_cnt = (term_cnt != 3'h0) ? term_cnt - 3'h1 : 3'h0;
    end
    next_state = state;
    next_cke = CKE_OUT;
    next_lvl_cnt = 6'h00;
    next_dqs_oe = 1'b0;
    next_dqs = 1'b0;
    if (go && cmd == dpot_pkg::CMD_PD_ENTER)
    begin
      next_state = dpot_pkg::ST_PWRDN;
      next_cke = 1'b0;
    end
    else if (go && cmd == dpot_pkg::CMD_PD_EXIT)
    begin
      next_state = dpot_pkg::ST_ACTIVE;
      next_cke = 1'b1;
    end
    else if (go && cmd == dpot_pkg::CMD_LEVEL)
    begin
      next_state = dpot_pkg::ST_LEVEL;
    end
    else if (state == dpot_pkg::ST_LEVEL)
    begin
      // one strobe pulse, then drive released and back to active
      next_lvl_cnt = lvl_cnt + 6'h01;
      next_dqs_oe = (lvl_cnt >= 6'(dpot_pkg::LEVELING_STROBE_ENABLE_DELAY - 1))
        && (lvl_cnt < 6'(dpot_pkg::LEVELING_FIRST_STROBE_DELAY));
      next_dqs = (lvl_cnt
        == 6'(dpot_pkg::LEVELING_FIRST_STROBE_DELAY - 1));
      if (lvl_cnt == 6'(dpot_pkg::LEVELING_FIRST_STROBE_DELAY))
        next_state = dpot_pkg::ST_ACTIVE;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      state <= dpot_pkg::ST_ACTIVE;
      pd_wait <= 7'h00;
      rfc_wait <= 3'h0;
      exit_wait <= 4'h0;
      ref_cnt <= 9'h000;
      term_cnt <= 3'h0;
      lvl_cnt <= 6'h00;
      chop_q <= 1'b0;
      REQ_DONE_OUT <= 1'b0;
      REQ_REJECT_OUT <= 1'b0;
      CMD_VALID_OUT <= 1'b0;
      CMD_CODE_OUT <= 4'h0;
      CKE_OUT <= 1'b1;
      TERM_OUT <= 1'b0;
      DQS_OE_OUT <= 1'b0;
      DQS_OUT <= 1'b0;
      REFRESH_DUE_OUT <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pd_wait <= next_pd_wait;
      rfc_wait <= next_rfc_wait;
      exit_wait <= next_exit_wait;
      ref_cnt <= next_ref_cnt;
      term_cnt <= next_term_cnt;
      lvl_cnt <= next_lvl_cnt;
      chop_q <= next_chop_q;
      REQ_DONE_OUT <= next_done;
      REQ_REJECT_OUT <= next_reject;
      CMD_VALID_OUT <= next_cmd_valid;
      CMD_CODE_OUT <= next_cmd_code;
      CKE_OUT <= next_cke;
      TERM_OUT <= next_term;
      DQS_OE_OUT <= next_dqs_oe;
      DQS_OUT <= next_dqs;
      REFRESH_DUE_OUT <= next_ref_due;
    end
  end

  // checking helpers: cycles since write, write-ap, refresh, modeset, exit
  logic [4:0] ev;
  logic [6:0] since [5];
  logic       cke_q;
  assign ev[0] = CMD_VALID_OUT && CMD_CODE_OUT == 4'(dpot_pkg::CMD_WRITE);
  assign ev[1] = CMD_VALID_OUT && CMD_CODE_OUT == 4'(dpot_pkg::CMD_WRITE_AP);
  assign ev[2] = CMD_VALID_OUT && CMD_CODE_OUT == 4'(dpot_pkg::CMD_REFRESH);
  assign ev[3] = CMD_VALID_OUT && (CMD_CODE_OUT == 4'(dpot_pkg::CMD_MODESET)
    || CMD_CODE_OUT == 4'(dpot_pkg::CMD_LEVEL));
  assign ev[4] = CKE_OUT && !cke_q;
  always_ff @(posedge CLK_IN)
  begin
    cke_q <= RST_IN ? 1'b1 : CKE_OUT;
  end
  for (genvar i = 0; i < 5; i++)
  begin : g_since
    always_ff @(posedge CLK_IN)
    begin
      if (RST_IN)
        since[i] <= 7'h7f;
      else if (ev[i])
        since[i] <= 7'h01;
      else if (since[i] != 7'h7f)
        since[i] <= since[i] + 7'h01;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_write_pd;
    $fell(CKE_OUT) |-> since[0] >= write_pd_delay;
  endproperty
  a_write_pd: assert property (p_write_pd)
    else $error("power-down too soon after write");
  property p_write_ap_pd;
    $fell(CKE_OUT) |-> since[1] >= write_ap_pd_delay;
  endproperty
  a_write_ap_pd: assert property (p_write_ap_pd)
    else $error("power-down too soon after write-autoprecharge");
  property p_ref_pd;
    ev[2] |-> !$fell(CKE_OUT);
  endproperty
  a_ref_pd: assert property (p_ref_pd)
    else $error("power-down in the refresh cycle");
  property p_mode_pd;
    $fell(CKE_OUT) |-> since[3] >= 7'(dpot_pkg::MODE_UPDATE_DELAY);
  endproperty
  a_mode_pd: assert property (p_mode_pd)
    else $error("power-down inside mode update delay");
  property p_term_short;
    (ev[0] || ev[1]) && chop_q |-> TERM_OUT [*4];
  endproperty
  a_term_short: assert property (p_term_short)
    else $error("termination high time short");
  property p_term_long;
    (ev[0] || ev[1]) && !chop_q |-> TERM_OUT [*6];
  endproperty
  a_term_long: assert property (p_term_long)
    else $error("termination high time long");
  property p_lvl_strobe;
    ev[3] && CMD_CODE_OUT == 4'(dpot_pkg::CMD_LEVEL) |-> ##40 DQS_OUT;
  endproperty
  a_lvl_strobe: assert property (p_lvl_strobe)
    else $error("leveling strobe not at 40 cycles");
  // counter instead of a long repetition: strobe never earlier
  property p_lvl_strobe_early;
    DQS_OUT |-> since[3] == 7'(dpot_pkg::LEVELING_FIRST_STROBE_DELAY);
  endproperty
  a_lvl_strobe_early: assert property (p_lvl_strobe_early)
    else $error("leveling strobe too early");
  property p_lvl_enable;
    CMD_VALID_OUT && CMD_CODE_OUT == 4'(dpot_pkg::CMD_LEVEL)
      |-> ##25 $rose(DQS_OE_OUT);
  endproperty
  a_lvl_enable: assert property (p_lvl_enable)
    else $error("strobe drive not enabled at 25 cycles");
  property p_rfc;
    ev[2] |=> !(CMD_VALID_OUT && (CMD_CODE_OUT == 4'(dpot_pkg::CMD_ACTIVATE)
      || CMD_CODE_OUT == 4'(dpot_pkg::CMD_REFRESH))) [*4];
  endproperty
  a_rfc: assert property (p_rfc)
    else $error("activate or refresh inside refresh cycle time");
  property p_ref_due;
    REFRESH_DUE_OUT && state == dpot_pkg::ST_ACTIVE && REQ_VALID_IN
      && cmd != dpot_pkg::CMD_REFRESH && cmd != dpot_pkg::CMD_NOP
      |=> REQ_REJECT_OUT;
  endproperty
  a_ref_due: assert property (p_ref_due)
    else $error("command taken while refresh due");
  property p_exit_dll;
    CMD_VALID_OUT && CMD_CODE_OUT >= 4'(dpot_pkg::CMD_READ)
      && CMD_CODE_OUT <= 4'(dpot_pkg::CMD_WRITE_AP)
      |-> since[4] >= 7'(dpot_pkg::EXIT_DLL_CYCLES);
  endproperty
  a_exit_dll: assert property (p_exit_dll)
    else $error("locked-loop command too soon after exit");

  c_write_pd: cover property (ev[0] ##[1:120] $fell(CKE_OUT));
  c_level: cover property ($rose(DQS_OUT));
  c_refresh: cover property ($rose(REFRESH_DUE_OUT) ##[1:20] ev[2]);
  c_exit_read: cover property (ev[4] ##[1:20] CMD_VALID_OUT);

endmodule
`default_nettype wire

// ---- src/dpot_pkg.sv ----
// package: command codes, states and timing constants for the host
package dpot_pkg;

  localparam int CLK_PERIOD_NS = 25;

  // write recovery in ns, plain default for the attached part
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int WRITE_RECOVERY_CYCLES =
    (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int REFRESH_CYCLE_TIME_NS = 110;
  localparam int REFRESH_CYCLE_CYCLES =
    (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int REFRESH_INTERVAL_AVG_NS = 7800;
  localparam int REFRESH_INTERVAL_HOT_NS = 3900;
  localparam int REFRESH_INTERVAL_CYCLES =
    REFRESH_INTERVAL_AVG_NS / CLK_PERIOD_NS;
  localparam int REFRESH_INTERVAL_HOT_CYCLES =
    REFRESH_INTERVAL_HOT_NS / CLK_PERIOD_NS;
  localparam int REFRESH_MARGIN_CYCLES = 8;

  localparam int EXIT_FAST_NS = 6;
  localparam int EXIT_FAST_MIN = 3;
  localparam int EXIT_DLL_NS = 24;
  localparam int EXIT_DLL_MIN = 10;
  localparam int EXIT_FAST_CYCLES =
    ((EXIT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > EXIT_FAST_MIN) ?
    (EXIT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : EXIT_FAST_MIN;
  localparam int EXIT_DLL_CYCLES =
    ((EXIT_DLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > EXIT_DLL_MIN) ?
    (EXIT_DLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : EXIT_DLL_MIN;

  // mode update delay in cycles, plain default
  localparam int MODE_UPDATE_DELAY = 12;
  localparam int REFRESH_TO_POWERDOWN_DELAY = 1;
  localparam int CHOP4_FIXED_EXTRA = 2;
  localparam int BURST_EIGHT_EXTRA = 4;
  localparam int WRITE_AP_EXTRA = 1;
  localparam int TERM_HIGH_TIME_SHORT = 4;
  localparam int TERM_HIGH_TIME_LONG = 6;
  localparam int LEVELING_STROBE_ENABLE_DELAY = 25;
  localparam int LEVELING_FIRST_STROBE_DELAY = 40;

  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_ACTIVATE = 4'h1,
    CMD_READ     = 4'h2,
    CMD_READ_AP  = 4'h3,
    CMD_WRITE    = 4'h4,
    CMD_WRITE_AP = 4'h5,
    CMD_PRECHG   = 4'h6,
    CMD_REFRESH  = 4'h7,
    CMD_MODESET  = 4'h8,
    CMD_LEVEL    = 4'h9,
    CMD_PD_ENTER = 4'ha,
    CMD_PD_EXIT  = 4'hb
  } dpot_cmd_t;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_PWRDN  = 2'h1,
    ST_LEVEL  = 2'h2
  } dpot_state_t;

endpackage

// ---- tb/dpot_device_model.sv ----
// behavioural device model: termination latency, write start, power state
`timescale 1ns/1ps
`default_nettype none
module dpot_device_model (
  input  wire logic       clk_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [3:0] cmd_code_in,
  input  wire logic       cke_in,
  input  wire logic       term_in,
  input  wire logic [4:0] cwl_in,
  input  wire logic [4:0] al_in,
  input  wire logic       chop_fixed_in,
  output var  logic       term_on_out,
  output var  logic       write_start_out,
  output var  logic       low_power_out
);
  logic [63:0] term_hist = '0;
  logic [63:0] wr_hist   = '0;
  int          busy      = 0;
  int          wl;
  logic        is_wr;
  always_comb wl = int'(cwl_in) + int'(al_in);
  always_comb is_wr = cmd_valid_in &&
    (cmd_code_in == dpot_pkg::CMD_WRITE ||
     cmd_code_in == dpot_pkg::CMD_WRITE_AP);
  always_ff @(posedge clk_in)
  begin
    term_hist <= {term_hist[62:0], term_in};
    wr_hist   <= {wr_hist[62:0], is_wr};
    // work in flight still finishes after clock enable drops
    if (cmd_valid_in && cmd_code_in != dpot_pkg::CMD_NOP)
      busy <= dpot_pkg::REFRESH_CYCLE_CYCLES;
    else if (busy > 0)
      busy <= busy - 1;
  end
  // termination follows control by write latency minus two
  assign term_on_out = term_hist[wl - 3];
  // fixed chop starts the internal write two cycles earlier
  assign write_start_out = wr_hist[wl + (chop_fixed_in ? 1 : 3)];
  assign low_power_out = !cke_in && busy == 0;
endmodule
`default_nettype wire

// ---- tb/dpot_host_tb.sv ----
// self-checking bench for the host timing guard
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %0d got %0d", nm, e, g); end end
module dpot_host_tb;
  localparam int RC = (dpot_pkg::WRITE_RECOVERY_TIME_NS +
    dpot_pkg::CLK_PERIOD_NS - 1) / dpot_pkg::CLK_PERIOD_NS;
  logic        clk, rst, vld, chop, cfix, hot, ok;
  logic [3:0]  cmd, code;
  logic [4:0]  column_write_latency, al, rec;
  logic        done, rej, cv, cke, term, dqs_oe, dqs, due, ton, wst, lowp;
  logic [31:0] lfsr = 32'he2f2;
  int          miscompares = 0;
  int          num_checks = 0;
  int          n, d, run = 0, last_run = 0, ws_cnt = 0;
  dpot_host dut (.CLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(vld),
    .REQ_CMD_IN(cmd), .REQ_CHOP_IN(chop), .CFG_COL_WR_LAT_IN(column_write_latency),
    .CFG_ADD_LAT_IN(al), .CFG_RECOV_IN(rec), .CFG_CHOP4_FIXED_IN(cfix),
    .CFG_HOT_IN(hot), .REQ_DONE_OUT(done), .REQ_REJECT_OUT(rej),
    .CMD_VALID_OUT(cv), .CMD_CODE_OUT(code), .CKE_OUT(cke),
    .TERM_OUT(term), .DQS_OE_OUT(dqs_oe), .DQS_OUT(dqs),
    .REFRESH_DUE_OUT(due));
  dpot_device_model mem (.clk_in(clk), .cmd_valid_in(cv),
    .cmd_code_in(code), .cke_in(cke), .term_in(term), .cwl_in(column_write_latency),
    .al_in(al), .chop_fixed_in(cfix), .term_on_out(ton),
    .write_start_out(wst), .low_power_out(lowp));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // length of the last termination pulse and count of write starts
  always @(posedge clk)
  begin
    if (term)
      run <= run + 1;
    else
    begin
      if (run > 0)
        last_run <= run;
      run <= 0;
    end
    if (wst)
      ws_cnt <= ws_cnt + 1;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one request, answer read at the edge after it is taken
  task automatic one(input logic [3:0] c, input logic ch, output logic r);
    vld <= 1'b1;
    cmd <= c;
    chop <= ch;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    r = done;
    `CHK("answer", 1'b1, done ^ rej)
  endtask
  // re-present every cycle; k is the take that was accepted
  task automatic poll(input logic [3:0] c, output int k);
    k = 0;
    vld <= 1'b1;
    cmd <= c;
    chop <= 1'b0;
    @(posedge clk);
    while (done !== 1'b1 && k < 600)
    begin
      @(posedge clk);
      k++;
    end
    vld <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1; vld = 1'b0; cmd = 4'h0; chop = 1'b0; cfix = 1'b0;
    hot = 1'b0; column_write_latency = 5'h05; al = 5'h00; rec = 5'h06;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("reset", 5'h10, {cke, term, dqs_oe, dqs, due})
    one(dpot_pkg::CMD_REFRESH, 1'b0, ok);
    poll(dpot_pkg::CMD_REFRESH, n);
    `CHK("ref_gap", 4, n)
    poll(dpot_pkg::CMD_PD_ENTER, n);
    `CHK("ref_pd", 1, n)
    repeat (8) @(posedge clk);
    `CHK("low_power", 1'b1, lowp)
    one(dpot_pkg::CMD_PD_EXIT, 1'b0, ok);
    repeat (12) @(posedge clk);
    $display("test refresh_spacing done");
    one(dpot_pkg::CMD_MODESET, 1'b0, ok);
    poll(dpot_pkg::CMD_PD_ENTER, n);
    `CHK("modeset_pd", dpot_pkg::MODE_UPDATE_DELAY - 1, n)
    one(dpot_pkg::CMD_PD_EXIT, 1'b0, ok);
    repeat (12) @(posedge clk);
    $display("test modeset done");
    one(dpot_pkg::CMD_LEVEL, 1'b0, ok);
    for (int k = 2; k < 44; k++)
    begin
      #1;
      `CHK("strobe_en", k >= 26 && k <= 41, dqs_oe)
      `CHK("strobe", k == 41, dqs)
      @(posedge clk);
    end
    poll(dpot_pkg::CMD_ACTIVATE, n);
    `CHK("level_end", 1, n)
    $display("test leveling done");
    for (int i = 1; i <= 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      column_write_latency <= 5'(5 + lfsr[2:0]);
      al <= 5'(lfsr[4:3]);
      rec <= 5'(5 + lfsr[7:5]);
      cfix <= lfsr[8];
      poll(dpot_pkg::CMD_REFRESH, n);
      d = int'(column_write_latency) + int'(al) + (cfix ? 2 : 4);
      one(dpot_pkg::CMD_WRITE, lfsr[9], ok);
      poll(dpot_pkg::CMD_PD_ENTER, n);
      `CHK("wr_pd", d + RC - 1, n)
      `CHK("cke", 1'b0, cke)
      `CHK("term_len", (cfix | lfsr[9]) ? 4 : 6, last_run)
      one(dpot_pkg::CMD_PD_EXIT, 1'b0, ok);
      poll(dpot_pkg::CMD_ACTIVATE, n);
      `CHK("exit_fast", dpot_pkg::EXIT_FAST_CYCLES - 1, n)
      // writes count as locked-loop commands, so let the long exit pass
      repeat (8) @(posedge clk);
      one(dpot_pkg::CMD_WRITE_AP, 1'b0, ok);
      `CHK("wrap_taken", 1'b1, ok)
      poll(dpot_pkg::CMD_PD_ENTER, n);
      `CHK("wrap_pd", d + int'(rec), n)
      one(dpot_pkg::CMD_PD_EXIT, 1'b0, ok);
      poll(dpot_pkg::CMD_READ, n);
      `CHK("exit_dll", dpot_pkg::EXIT_DLL_CYCLES - 1, n)
      `CHK("write_starts", 2 * i, ws_cnt)
    end
    $display("test write_powerdown done");
    for (int h = 0; h < 2; h++)
    begin
      hot <= h[0];
      poll(dpot_pkg::CMD_REFRESH, n);
      d = (h ? 3900 : 7800) / 25 - 8;
      n = 0;
      while (due !== 1'b1 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      `CHK("due_time", 1'b1, n >= d - 8 && n <= d)
      one(dpot_pkg::CMD_ACTIVATE, 1'b0, ok);
      `CHK("due_block", 1'b0, ok)
      one(dpot_pkg::CMD_REFRESH, 1'b0, ok);
      `CHK("due_ref", 1'b1, ok)
      `CHK("due_clear", 1'b0, due)
    end
    $display("test refresh_interval done");
    print_verdict();
  end
endmodule
`default_nettype wire
